// >>> hdl/mal_pkg.sv
// Package with the register map, field layout and types of the motion linker.
package mal_pkg;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] MAL_STATUS_OFS = 8'h00;
    localparam logic [7:0] MAL_ACT_THRESH_OFS = 8'h04;
    localparam logic [7:0] MAL_ACT_TIME_OFS = 8'h08;
    localparam logic [7:0] MAL_INACT_THRESH_OFS = 8'h0C;
    localparam logic [7:0] MAL_INACT_TIME_OFS = 8'h10;
    localparam logic [7:0] MAL_CTRL_OFS = 8'h14;
    localparam logic [7:0] MAL_INT_MAP_OFS = 8'h18;
    localparam logic [7:0] MAL_FIFO_CTRL_OFS = 8'h1C;
    localparam logic [7:0] MAL_FIFO_COUNT_OFS = 8'h20;
    localparam logic [7:0] MAL_FIFO_XY_OFS = 8'h24;
    localparam logic [7:0] MAL_FIFO_Z_OFS = 8'h28;
    localparam logic [7:0] MAL_DATA_BASE_OFS = 8'h2C;
    localparam logic [7:0] MAL_DATA_LAST_OFS = 8'h48;
    localparam logic [7:0] MAL_POWER_OFS = 8'h4C;
    localparam logic [7:0] MAL_ID_OFS = 8'h50;

    // Status register bit positions.
    localparam int MAL_ST_ACT = 0;
    localparam int MAL_ST_INACT = 1;
    localparam int MAL_ST_AWAKE = 2;
    localparam int MAL_ST_FROZEN = 3;
    localparam int MAL_ST_WAKEUP = 4;

    // Control register bit positions.
    localparam int MAL_CT_ACT_EN = 0;
    localparam int MAL_CT_ACT_REF = 1;
    localparam int MAL_CT_INACT_EN = 2;
    localparam int MAL_CT_INACT_REF = 3;
    localparam int MAL_CT_LINK_LO = 4;
    localparam int MAL_CT_AUTOSLEEP = 6;

    // Interrupt map bit positions, pin two sits at MAL_MAP_PIN2 above.
    localparam int MAL_MAP_AWAKE = 0;
    localparam int MAL_MAP_ACT = 1;
    localparam int MAL_MAP_INACT = 2;
    localparam int MAL_MAP_PIN2 = 4;

    // Reset values.
    localparam logic [6:0] MAL_CTRL_RST = 7'h00;
    localparam logic [7:0] MAL_MAP_RST = 8'h00;
    localparam logic MAL_AWAKE_RST = 1'b1;
    localparam logic MAL_WAKEUP_RST = 1'b0;

    // Documented sizes.
    localparam int MAL_SAMPLE_W = 12;
    localparam int MAL_ACT_TIME_W = 8;
    localparam int MAL_INACT_TIME_W = 16;
    localparam int MAL_FIFO_DEPTH = 512;

    // Clock of the block: 40 MHz.
    localparam int MAL_CLK_PERIOD_NS = 25;

    typedef enum logic [1:0]
    {
        MAL_LINK_DEFAULT = 2'b00,
        MAL_LINK_LINKED = 2'b01,
        MAL_LINK_LOOP = 2'b11
    } mal_link_t;

    // Detector phase in linked and loop operation.
    typedef enum logic [1:0]
    {
        MAL_PH_ACT = 2'b01,
        MAL_PH_INACT = 2'b10
    } mal_phase_t;

    // Buffer modes.
    typedef enum logic [2:0]
    {
        MAL_FIFO_OFF = 3'b001,
        MAL_FIFO_STREAM = 3'b010,
        MAL_FIFO_TRIG = 3'b100
    } mal_fifo_t;

    typedef struct packed
    {
        logic signed [MAL_SAMPLE_W-1:0] x;
        logic signed [MAL_SAMPLE_W-1:0] y;
        logic signed [MAL_SAMPLE_W-1:0] z;
    } mal_axes_t;

    typedef struct packed
    {
        mal_axes_t axes;
        logic signed [MAL_SAMPLE_W-1:0] temp;
    } mal_sample_t;

endpackage

// >>> hdl/mal_linker.sv
// Activity and inactivity linker with sample buffer and AHB-Lite registers.
// Function
// R1 - Activity timer programmable from one sample up to about twenty seconds.
// R2 - Activity timer only in measurement mode; wake-up mode uses one sample.
// R3 - Inactivity event after staying below threshold for the set duration.
// R4 - Absolute inactivity: consecutive raw samples all below the threshold.
// R5 - Referenced inactivity: samples within deviation of a held reference.
// R6 - Inactivity timer counts samples, accepts one to 65535.
// R7 - Any motion sample restarts the inactivity count.
// R8 - Host must enable both detectors; both are off after reset.
// R9 - Default mode: both detectors run, events latch until host reads.
// R10 - Linked mode: only one detector runs, alternating after each event.
// R11 - Linked mode: next event armed only after host read the current one.
// R12 - Loop mode: alternate like linked, clear and rearm autonomously.
// R13 - Autosleep in linked or loop switches wake-up and measurement mode.
// R14 - Autosleep setting ignored in default mode.
// R15 - Awake flag set on activity, cleared on inactivity.
// R16 - Awake flag routable to interrupt pin one or two as a level.
// R17 - Sample buffer holds 512 entries in first-in first-out order.
// R18 - Triggered mode stores continuously, freezes pre-event data on activity.
// R19 - Consecutive reads drain the buffer in one burst of any length.
// R20 - Each result is twelve bits over two byte registers, axes consecutive.
// R21 - Activity event after staying above threshold for the set duration.
// R22 - Reference captured on detection start, per link mode as described.
// R23 - Per sample: activity if any axis over, inactivity if all under.
`timescale 1ns/1ps
module mal_linker
    import mal_pkg::*;
#(
    parameter int FIFO_DEPTH = MAL_FIFO_DEPTH,
    parameter int SAMPLE_W = MAL_SAMPLE_W,
    // Arbitrary identification value.
    parameter logic [7:0] ID_CODE = 8'h5A
)
(
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // AHB-Lite slave.
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // Samples from the converter, same clock domain.
    input wire logic sample_valid_in,
    input wire mal_sample_t sample_in,
    // Pins and mode.
    output logic interrupt_pin_one_out,
    output logic interrupt_pin_two_out,
    output logic wakeup_mode_out
);

    localparam int AW = $clog2(FIFO_DEPTH);

    initial
    begin
        if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH)
            $error("FIFO_DEPTH must be a power of two of at least two.");
        if (SAMPLE_W != MAL_SAMPLE_W)
            $error("SAMPLE_W must match the sample struct width.");
    end

    function automatic logic [12:0] deviation(
        input logic signed [11:0] a,
        input logic signed [11:0] b
    );
        logic signed [12:0] d;
        d = 13'(a) - 13'(b);
        deviation = d[12] ? 13'(-d) : 13'(d);
    endfunction

    function automatic logic [7:0] byte_of(
        input logic signed [11:0] v,
        input logic hi
    );
        byte_of = hi ? {{4{v[11]}}, v[11:8]} : v[7:0];
    endfunction

    // Bus pipeline.
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic take;
    logic rd_take;
    logic [31:0] rdata_next;
    logic wr_commit;

    // Software registers.
    logic [11:0] act_thresh_reg;
    logic [MAL_ACT_TIME_W-1:0] act_time_reg;
    logic [11:0] inact_thresh_reg;
    logic [MAL_INACT_TIME_W-1:0] inact_time_reg;
    logic [6:0] ctrl_reg;
    logic [7:0] map_reg;
    mal_fifo_t fifo_mode_reg;

    // Detector state.
    logic act_flag_reg;
    logic inact_flag_reg;
    logic awake_reg;
    logic wakeup_reg;
    mal_phase_t phase_reg;
    logic [MAL_ACT_TIME_W-1:0] act_cnt_reg;
    logic [MAL_INACT_TIME_W-1:0] inact_cnt_reg;
    mal_axes_t act_ref_reg;
    mal_axes_t inact_ref_reg;
    logic act_ref_pend_reg;
    logic inact_ref_pend_reg;
    mal_sample_t last_reg;

    // Buffer state.
    mal_axes_t mem [FIFO_DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic frozen_reg;

    mal_link_t link;
    logic chain;
    logic status_rd;
    logic act_hit;
    logic inact_ok;
    logic act_active;
    logic inact_active;
    logic act_event;
    logic inact_event;
    logic [MAL_ACT_TIME_W-1:0] act_need;
    logic [MAL_INACT_TIME_W-1:0] inact_need;
    logic fifo_wr;
    logic fifo_pop;
    logic fifo_drop;
    logic fifo_full;
    mal_axes_t act_base;
    mal_axes_t inact_base;
    logic [7:0] data_ofs;

    assign take = hsel_in && htrans_in[1] && hready_in;
    // A read that follows a write waits one cycle so it sees the new value.
    assign hreadyout_out = !(wr_pend_reg && take && !hwrite_in);
    assign rd_take = take && !hwrite_in && hreadyout_out;
    assign wr_commit = wr_pend_reg;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_reg;

    assign link = mal_link_t'(ctrl_reg[MAL_CT_LINK_LO +: 2]);
    assign chain = (link == MAL_LINK_LINKED) || (link == MAL_LINK_LOOP);
    assign status_rd = rd_take && haddr_in == MAL_STATUS_OFS;
    assign act_need = (act_time_reg == '0) ? MAL_ACT_TIME_W'(1) : act_time_reg;
    assign inact_need = (inact_time_reg == '0) ?
        MAL_INACT_TIME_W'(1) : inact_time_reg;
    assign act_base = ctrl_reg[MAL_CT_ACT_REF] ? act_ref_reg : '0;
    assign inact_base = ctrl_reg[MAL_CT_INACT_REF] ? inact_ref_reg : '0;
    assign data_ofs = haddr_in - MAL_DATA_BASE_OFS;

    // Any axis above threshold counts as motion; all under counts as still.
    always_comb
    begin
        act_hit = 1'b0;
        inact_ok = 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            if (deviation(sample_in.axes[12*i +: 12], act_base[12*i +: 12])
                > 13'(act_thresh_reg))
                act_hit = 1'b1; // R23
            if (deviation(sample_in.axes[12*i +: 12], inact_base[12*i +: 12])
                >= 13'(inact_thresh_reg))
                inact_ok = 1'b0; // R4 R5 R23
        end
    end

    // Arming per link mode; in linked mode the previous event must be read.
    always_comb
    begin
        if (!chain)
        begin
            act_active = ctrl_reg[MAL_CT_ACT_EN] && !act_flag_reg; // R9
            inact_active = ctrl_reg[MAL_CT_INACT_EN] && !inact_flag_reg; // R9
        end
        else
        begin
            act_active = ctrl_reg[MAL_CT_ACT_EN] && phase_reg == MAL_PH_ACT
                && (link == MAL_LINK_LOOP || !inact_flag_reg); // R10 R11 R12
            inact_active = ctrl_reg[MAL_CT_INACT_EN]
                && phase_reg == MAL_PH_INACT
                && (link == MAL_LINK_LOOP || !act_flag_reg); // R10 R11 R12
        end
    end

    // Activity timer only in measurement mode; one sample suffices in wake-up mode.
    assign act_event = sample_valid_in && act_active && act_hit
        && !(act_ref_pend_reg && ctrl_reg[MAL_CT_ACT_REF])
        && (wakeup_reg || act_cnt_reg + 1'b1 >= act_need); // R1 R2 R21
    assign inact_event = sample_valid_in && inact_active && inact_ok
        && !(inact_ref_pend_reg && ctrl_reg[MAL_CT_INACT_REF])
        && (inact_cnt_reg + 1'b1 >= inact_need); // R3 R6

    // Consecutive qualifying samples; a failing sample restarts the count.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            act_cnt_reg <= '0;
            inact_cnt_reg <= '0;
        end
        else if (sample_valid_in)
        begin
            if (act_active && act_hit && !act_event)
                act_cnt_reg <= act_cnt_reg + 1'b1; // R1
            else
                act_cnt_reg <= '0;
            if (inact_active && inact_ok && !inact_event)
                inact_cnt_reg <= inact_cnt_reg + 1'b1; // R6
            else
                inact_cnt_reg <= '0; // R7
        end
    end

    // Event flags: a status read clears them, a new event wins over it.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            act_flag_reg <= 1'b0;
            inact_flag_reg <= 1'b0;
        end
        else
        begin
            if (act_event)
                act_flag_reg <= 1'b1; // R9
            else if (status_rd || (link == MAL_LINK_LOOP && inact_event))
                act_flag_reg <= 1'b0; // R12
            if (inact_event)
                inact_flag_reg <= 1'b1; // R9
            else if (status_rd || (link == MAL_LINK_LOOP && act_event))
                inact_flag_reg <= 1'b0; // R12
        end
    end

    // Phase, awake status and autosleep.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            phase_reg <= MAL_PH_ACT;
            awake_reg <= MAL_AWAKE_RST;
            wakeup_reg <= MAL_WAKEUP_RST;
        end
        else
        begin
            if (!chain)
                phase_reg <= MAL_PH_ACT;
            else if (act_event)
                phase_reg <= MAL_PH_INACT; // R10
            else if (inact_event)
                phase_reg <= MAL_PH_ACT; // R10
            if (act_event)
                awake_reg <= 1'b1; // R15
            else if (inact_event)
                awake_reg <= 1'b0; // R15
            if (chain && ctrl_reg[MAL_CT_AUTOSLEEP] && act_event)
                wakeup_reg <= 1'b0; // R13 R14
            else if (chain && ctrl_reg[MAL_CT_AUTOSLEEP] && inact_event)
                wakeup_reg <= 1'b1; // R13 R14
            else if (wr_commit && wr_addr_reg == MAL_POWER_OFS)
                wakeup_reg <= hwdata_in[0];
        end
    end

    // References are taken from the next sample after detection restarts.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            act_ref_pend_reg <= 1'b0;
            inact_ref_pend_reg <= 1'b0;
            act_ref_reg <= '0;
            inact_ref_reg <= '0;
        end
        else
        begin
            if (wr_commit && wr_addr_reg == MAL_CTRL_OFS && !wakeup_reg
                && hwdata_in[MAL_CT_ACT_EN] && !ctrl_reg[MAL_CT_ACT_EN])
                act_ref_pend_reg <= 1'b1; // R22
            else if ((chain && inact_event) || (!chain && act_event))
                act_ref_pend_reg <= 1'b1; // R22
            else if (sample_valid_in && act_ref_pend_reg)
                act_ref_pend_reg <= 1'b0;
            if (act_ref_pend_reg && sample_valid_in)
                act_ref_reg <= sample_in.axes; // R22
            if (wr_commit && wr_addr_reg == MAL_CTRL_OFS
                && hwdata_in[MAL_CT_INACT_EN] && !ctrl_reg[MAL_CT_INACT_EN])
                inact_ref_pend_reg <= 1'b1; // R5
            else if ((chain && act_event) || (!chain && inact_event))
                inact_ref_pend_reg <= 1'b1; // R5
            else if (sample_valid_in && inact_ref_pend_reg)
                inact_ref_pend_reg <= 1'b0;
            if (inact_ref_pend_reg && sample_valid_in)
                inact_ref_reg <= sample_in.axes; // R5
        end
    end

    // Latest result for the byte-wide data registers.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            last_reg <= '0;
        else if (sample_valid_in)
            last_reg <= sample_in; // R20
    end

    // Sample buffer. Stream drops the oldest entry when full, so the
    // triggered capture always holds the newest history before the event.
    assign fifo_full = count_reg == (AW+1)'(FIFO_DEPTH);
    assign fifo_wr = sample_valid_in && fifo_mode_reg != MAL_FIFO_OFF
        && !frozen_reg; // R17 R18
    assign fifo_pop = rd_take && haddr_in == MAL_FIFO_Z_OFS
        && count_reg != '0; // R19
    assign fifo_drop = fifo_wr && fifo_full && !fifo_pop;

    always_ff @(posedge clk_in)
    begin
        if (fifo_wr)
            mem[wr_ptr_reg] <= sample_in.axes; // R17
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            frozen_reg <= 1'b0;
        end
        else if (wr_commit && wr_addr_reg == MAL_FIFO_CTRL_OFS)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            frozen_reg <= 1'b0;
        end
        else
        begin
            if (fifo_wr)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (fifo_pop || fifo_drop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1; // R19
            if (fifo_wr && !fifo_pop && !fifo_full)
                count_reg <= count_reg + 1'b1;
            else if (!fifo_wr && fifo_pop)
                count_reg <= count_reg - 1'b1;
            if (fifo_mode_reg == MAL_FIFO_TRIG && act_event)
                frozen_reg <= 1'b1; // R18
        end
    end

    // Software register writes, committed in the write data phase.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= '0;
        end
        else
        begin
            wr_pend_reg <= take && hwrite_in;
            wr_addr_reg <= {haddr_in[7:2], 2'b00};
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            act_thresh_reg <= '0;
            act_time_reg <= '0;
            inact_thresh_reg <= '0;
            inact_time_reg <= '0;
            ctrl_reg <= MAL_CTRL_RST; // R8
            map_reg <= MAL_MAP_RST;
            fifo_mode_reg <= MAL_FIFO_OFF;
        end
        else if (wr_commit)
        begin
            case (wr_addr_reg)
                MAL_ACT_THRESH_OFS: act_thresh_reg <= hwdata_in[11:0];
                MAL_ACT_TIME_OFS: act_time_reg <= hwdata_in[7:0]; // R1
                MAL_INACT_THRESH_OFS: inact_thresh_reg <= hwdata_in[11:0];
                MAL_INACT_TIME_OFS: inact_time_reg <= hwdata_in[15:0]; // R6
                MAL_CTRL_OFS: ctrl_reg <= hwdata_in[6:0];
                MAL_INT_MAP_OFS: map_reg <= hwdata_in[7:0];
                MAL_FIFO_CTRL_OFS:
                    case (hwdata_in[1:0])
                        2'h1: fifo_mode_reg <= MAL_FIFO_STREAM;
                        2'h2: fifo_mode_reg <= MAL_FIFO_TRIG; // R18
                        default: fifo_mode_reg <= MAL_FIFO_OFF;
                    endcase
                default: ;
            endcase
        end
    end

    // Read data, taken into a flip-flop at the end of the address phase.
    always_comb
    begin
        rdata_next = 32'h00000000;
        case ({haddr_in[7:2], 2'b00})
            MAL_STATUS_OFS:
            begin
                rdata_next[MAL_ST_ACT] = act_flag_reg;
                rdata_next[MAL_ST_INACT] = inact_flag_reg;
                rdata_next[MAL_ST_AWAKE] = awake_reg; // R15
                rdata_next[MAL_ST_FROZEN] = frozen_reg;
                rdata_next[MAL_ST_WAKEUP] = wakeup_reg;
            end
            MAL_ACT_THRESH_OFS: rdata_next[11:0] = act_thresh_reg;
            MAL_ACT_TIME_OFS: rdata_next[7:0] = act_time_reg;
            MAL_INACT_THRESH_OFS: rdata_next[11:0] = inact_thresh_reg;
            MAL_INACT_TIME_OFS: rdata_next[15:0] = inact_time_reg;
            MAL_CTRL_OFS: rdata_next[6:0] = ctrl_reg;
            MAL_INT_MAP_OFS: rdata_next[7:0] = map_reg;
            MAL_FIFO_CTRL_OFS:
                rdata_next[1:0] = {fifo_mode_reg == MAL_FIFO_TRIG,
                    fifo_mode_reg == MAL_FIFO_STREAM};
            MAL_FIFO_COUNT_OFS: rdata_next[AW:0] = count_reg;
            MAL_FIFO_XY_OFS:
                if (count_reg != '0)
                    rdata_next[23:0] = {mem[rd_ptr_reg].y, mem[rd_ptr_reg].x};
            MAL_FIFO_Z_OFS:
                if (count_reg != '0)
                    rdata_next[11:0] = mem[rd_ptr_reg].z; // R19
            MAL_POWER_OFS: rdata_next[0] = wakeup_reg;
            MAL_ID_OFS: rdata_next[7:0] = ID_CODE;
            default:
                if (haddr_in >= MAL_DATA_BASE_OFS
                    && haddr_in <= MAL_DATA_LAST_OFS)
                begin
                    rdata_next[7:0] = byte_of(
                        last_reg[6'(36 - 12 * data_ofs[4:3]) +: 12],
                        data_ofs[2]); // R20
                end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            hrdata_reg <= 32'h00000000;
        else if (rd_take)
            hrdata_reg <= rdata_next;
    end

    // Pins carry levels; the awake map makes a plain motion switch.
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            interrupt_pin_one_out <= 1'b0;
            interrupt_pin_two_out <= 1'b0;
        end
        else
        begin
            interrupt_pin_one_out <= (map_reg[MAL_MAP_AWAKE] && awake_reg)
                || (map_reg[MAL_MAP_ACT] && act_flag_reg)
                || (map_reg[MAL_MAP_INACT] && inact_flag_reg); // R16
            interrupt_pin_two_out <=
                (map_reg[MAL_MAP_PIN2 + MAL_MAP_AWAKE] && awake_reg)
                || (map_reg[MAL_MAP_PIN2 + MAL_MAP_ACT] && act_flag_reg)
                || (map_reg[MAL_MAP_PIN2 + MAL_MAP_INACT]
                && inact_flag_reg); // R16
        end
    end

    assign wakeup_mode_out = wakeup_reg; // R2

endmodule

// >>> verification/mal_chk.sv
// Port checker for the motion linker, bound to its top module.
`timescale 1ns/1ps
module mal_chk
(
    // Watched ports.
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic hreadyout_out,
    input wire logic hresp_out,
    input wire logic sample_valid_in,
    input wire logic interrupt_pin_one_out,
    input wire logic interrupt_pin_two_out,
    input wire logic wakeup_mode_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic rd;
    logic wr;
    assign rd = hsel_in && htrans_in[1] && hready_in && !hwrite_in
        && hreadyout_out;
    assign wr = hsel_in && htrans_in[1] && hready_in && hwrite_in;
    a_resp_okay: assert property (!hresp_out)
        else $error("bad response");
    a_wait_single: assert property (!hreadyout_out |=> hreadyout_out)
        else $error("long wait");
    a_wait_cause: assert property (!hreadyout_out |-> $past(wr)
        && hsel_in && !hwrite_in) else $error("stray wait");
    a_rdata_hold: assert property (!rd |=> $stable(hrdata_out))
        else $error("read data moved");
    a_unmapped_zero: assert property (rd && haddr_in > 8'h50
        |=> hrdata_out == 32'h0) else $error("unmapped not zero");
    // Pins are registered after the flags, so a pin change lags its sample by two edges.
    a_wake_cause: assert property ($changed(wakeup_mode_out)
        |-> $past(sample_valid_in) || $past(wr, 2)) else $error("wake");
    a_pin_one: assert property ($changed(interrupt_pin_one_out)
        |-> $past(sample_valid_in, 2) || $past(rd, 2) || $past(wr, 3))
        else $error("pin one");
    a_pin_two: assert property ($changed(interrupt_pin_two_out)
        |-> $past(sample_valid_in, 2) || $past(rd, 2) || $past(wr, 3))
        else $error("pin two");
    a_rst_clean: assert property ($fell(rst_in) |-> !wakeup_mode_out
        && !interrupt_pin_one_out && hrdata_out == 32'h0) else $error("rst");
    c_wait: cover property (!hreadyout_out);
    c_sleep: cover property ($rose(wakeup_mode_out));
    c_pin: cover property ($fell(interrupt_pin_one_out));
endmodule
bind mal_linker mal_chk chk (.*);

// >>> verification/mal_host.sv
// Bus master model standing in for the host processor.
`timescale 1ns/1ps
module mal_host
(
    // Bus.
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [7:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [31:0] hwdata_out
);
    initial
    begin
        hsel_out = 1'b0;
        haddr_out = 8'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'b0;
        hwdata_out = 32'h0;
    end
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        hsel_out <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out <= a;
        hwrite_out <= w;
        @(posedge clk_in);
        while (!hready_in)
            @(posedge clk_in);
        hsel_out <= 1'b0;
        htrans_out <= 2'h0;
        hwdata_out <= d;
        @(posedge clk_in);
        while (!hready_in)
            @(posedge clk_in);
        r = hrdata_in;
        hwdata_out <= ~d;
    endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the motion linker.
`timescale 1ns/1ps
module tb_top;
    import mal_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic sv = 1'b0;
    mal_sample_t smp = '0;
    mal_sample_t s;
    logic hsel, hwrite, p1, p2, wk, rdy, resp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, r;
    int failures = 0;
    int num_checks = 0;
    int n, m, e = 4;
    mal_sample_t q[$];
    mal_host host (.clk_in(clk_in), .hready_in(rdy), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
        .hwrite_out(hwrite), .hwdata_out(hwdata));
    mal_linker dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(rdy),
        .hrdata_out(hrdata), .hreadyout_out(rdy), .hresp_out(resp),
        .sample_valid_in(sv), .sample_in(smp), .interrupt_pin_one_out(p1),
        .interrupt_pin_two_out(p2), .wakeup_mode_out(wk));
    initial forever #12.5 clk_in = ~clk_in;
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x)
        begin
            failures++;
            $display("MISMATCH %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(a, 1'b1, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        host.xfer(a, 1'b0, 32'h0, r);
        chk(r, x);
    endtask
    // Quiet axes stay under 20; an over sample puts one axis above 100.
    task automatic samp(input bit over);
        int k;
        k = $urandom_range(0, 2);
        s.axes = {12'($urandom_range(0, 19)), 12'($urandom_range(0, 19)),
            12'($urandom_range(0, 19))};
        if (over)
            s.axes[12*k +: 12] = 12'($urandom_range(101, 2047));
        s.temp = 12'($urandom);
        smp <= s;
        sv <= 1'b1;
        @(posedge clk_in);
        sv <= 1'b0;
        @(posedge clk_in);
        q.push_back(s);
    endtask
    initial
    begin
        #500000;
        failures++;
        print_verdict();
    end
    initial
    begin
        void'($urandom(32'h85CB));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd(MAL_CTRL_OFS, 32'h0);
        rd(MAL_STATUS_OFS, 32'h4);
        wr(MAL_ACT_THRESH_OFS, 32'h64);
        wr(MAL_ACT_TIME_OFS, 32'h3);
        wr(MAL_INACT_THRESH_OFS, 32'h14);
        wr(MAL_INACT_TIME_OFS, 32'h4);
        wr(MAL_INT_MAP_OFS, 32'h11);
        wr(MAL_FIFO_CTRL_OFS, 32'h1);
        wr(MAL_CTRL_OFS, 32'h45);
        repeat (30)
        begin
            n = $urandom_range(1, 4);
            m = $urandom_range(1, 5);
            e = e & 4;
            repeat (n) samp(1);
            repeat (m) samp(0);
            if (n > 2)
                e = 5;
            if (m > 3)
                e = (e & 1) | 2;
            rd(MAL_STATUS_OFS, e);
            chk(p1, e[2]);
            chk(p2, e[2]);
            chk(wk, 1'b0);
        end
        rd(MAL_FIFO_COUNT_OFS, q.size());
        while (q.size() > 0)
        begin
            s = q.pop_front();
            host.xfer(MAL_FIFO_XY_OFS, 1'b0, 32'h0, r);
            chk(r[23:0], {s.axes.y, s.axes.x});
            host.xfer(MAL_FIFO_Z_OFS, 1'b0, 32'h0, r);
            chk(r[11:0], {s.axes.z});
        end
        $display("default mode test done");
        wr(MAL_FIFO_CTRL_OFS, 32'h2);
        wr(MAL_CTRL_OFS, 32'h55);
        repeat (3) samp(1);
        repeat (4) samp(0);
        rd(MAL_STATUS_OFS, 32'hD);
        repeat (4) samp(0);
        rd(MAL_STATUS_OFS, 32'h1A);
        chk(wk, 1'b1);
        chk(p1, 1'b0);
        samp(1);
        rd(MAL_STATUS_OFS, 32'hD);
        chk(wk, 1'b0);
        host.xfer(MAL_DATA_BASE_OFS, 1'b0, 32'h0, r);
        chk(r[7:0], q[$].axes.x[7:0]);
        $display("linked mode test done");
        wr(MAL_CTRL_OFS, 32'h75);
        rd(MAL_CTRL_OFS, 32'h75);
        rd(8'h60, 32'h0);
        repeat (4) samp(0);
        chk(wk, 1'b1);
        samp(1);
        chk(wk, 1'b0);
        $display("loop mode test done");
        print_verdict();
    end
endmodule
